// *** hdl/tcs_pkg.sv ***
// Constants and carrier types for the timer run and flag control block.
package tcs_pkg;

	// ==========================================================
	// Register address and bit positions
	localparam logic [7:0] TCS_CTRL_ADDR  = 8'h88;
	localparam logic [7:0] TCS_CTRL_RESET = 8'h00;
	localparam int unsigned TCS_BIT_TYPE0 = 0;
	localparam int unsigned TCS_BIT_PEND0 = 1;
	localparam int unsigned TCS_BIT_TYPE1 = 2;
	localparam int unsigned TCS_BIT_PEND1 = 3;
	localparam int unsigned TCS_BIT_RUN0  = 4;
	localparam int unsigned TCS_BIT_OVF0  = 5;
	localparam int unsigned TCS_BIT_RUN1  = 6;
	localparam int unsigned TCS_BIT_OVF1  = 7;
	localparam int unsigned TCS_NBITS   = 8;

	// ==========================================================
	// Timer modes and roll-over values
	localparam logic [1:0]  TCS_MODE_13BIT  = 2'h0;
	localparam logic [1:0]  TCS_MODE_16BIT  = 2'h1;
	localparam logic [1:0]  TCS_MODE_RELOAD = 2'h2;
	localparam logic [1:0]  TCS_MODE_SPLIT  = 2'h3;
	localparam logic [12:0] TCS_MAX13       = 13'h1FFF;
	localparam logic [15:0] TCS_MAX16       = 16'hFFFF;
	localparam logic [7:0]  TCS_MAX8        = 8'hFF;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic       wr;
		logic       bit_wr;
		logic       rd;
		logic [7:0] addr;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
	} tcs_sfr_req_t;

	typedef struct packed {
		logic        inc;
		logic [15:0] count;
	} tcs_tick_t;

	typedef struct packed {
		logic ovf0;
		logic ovf1;
		logic pend0;
		logic pend1;
	} tcs_vec_ack_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic       irq0_prev;
		logic       irq1_prev;
		logic       run0_lo;
		logic       run0_hi;
		logic       run1;
		logic [7:0] rdata;
	} tcs_state_t;

	localparam tcs_state_t TCS_STATE_RESET = '{ctrl: TCS_CTRL_RESET, rdata: 8'h00, default: 1'b0};

endpackage : tcs_pkg

// *** hdl/tcs_timer_control.sv ***
// Timer run and flag control register with overflow, gating and external interrupt flags.
`timescale 1ns/100ps
// Functional notes
// [RULE1] Second timer overflow sets bit 7 flag; the code ignores it while the first timer is in split mode.
// [RULE2] Bit 7 cleared by software or vector.
// [RULE3] First timer overflow sets bit 5 flag.
// [RULE4] Bit 5 cleared by software or vector.
// [RULE5] Run bits 4 and 6 start/stop timers; in split mode the code makes bit 6 run the upper byte, not the second timer.
// [RULE6] First timer counts when ungated or input active.
// [RULE7] 13-bit mode flags on 0x1FFF roll-over.
// [RULE8] Split mode upper byte uses second timer bits.
// [RULE9] Type select: 0 level, 1 edge.
// [RULE10] Overflow beats a same-cycle software clear.
module tcs_timer_control (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire tcs_pkg::tcs_sfr_req_t sfr_req,
	output logic [7:0]                 sfr_rdata,
	input  wire tcs_pkg::tcs_vec_ack_t vec_ack,
	input  wire logic [1:0]            first_timer_mode,
	input  wire logic [1:0]            second_timer_mode,
	input  wire logic                  first_timer_gate_bit,
	input  wire logic                  second_timer_gate_bit,
	input  wire tcs_pkg::tcs_tick_t    first_timer_tick,
	input  wire logic                  first_timer_upper_byte_inc,
	input  wire tcs_pkg::tcs_tick_t    second_timer_tick,
	input  wire logic                  ext_irq0_input,
	input  wire logic                  ext_irq1_input,
	output logic [7:0]                 timer_run_and_flag_control,
	output logic                       first_timer_count_en,
	output logic                       first_timer_upper_count_en,
	output logic                       second_timer_count_en
);

	// ==========================================================
	// Decoding helpers
	// Overflow test shared by both timers; split and reload modes roll over on the low byte.
	function automatic logic tcs_overflow(input logic [1:0] mode, input tcs_pkg::tcs_tick_t tick);
		logic ov;
		ov = 1'b0;
		case (mode)
			tcs_pkg::TCS_MODE_13BIT: ov = tick.inc && (tick.count[12:0] == tcs_pkg::TCS_MAX13);
			tcs_pkg::TCS_MODE_16BIT: ov = tick.inc && (tick.count == tcs_pkg::TCS_MAX16);
			default:                 ov = tick.inc && (tick.count[7:0] == tcs_pkg::TCS_MAX8);
		endcase
		return ov;
	endfunction : tcs_overflow

	tcs_pkg::tcs_state_t s_q;
	tcs_pkg::tcs_state_t s_d;
	logic [7:0]          sw_hit;
	logic [7:0]          sw_val;
	logic                ctrl_sel;
	logic                ov0;
	logic                ov0_hi;
	logic                ov1;
	logic                set_ovf1;
	logic                pend0_edge;
	logic                pend1_edge;

	assign ctrl_sel = (sfr_req.addr == tcs_pkg::TCS_CTRL_ADDR);

	// Byte writes touch every bit; bit writes touch one bit and carry the value in data bit 0.
	for (genvar i = 0; i < tcs_pkg::TCS_NBITS; i++) begin : g_bit_wr
		assign sw_hit[i] = ctrl_sel && (sfr_req.wr || (sfr_req.bit_wr && (sfr_req.bit_sel == 3'(i))));
		assign sw_val[i] = sfr_req.wr ? sfr_req.wdata[i] : sfr_req.wdata[0];
	end

	// ==========================================================
	// Overflow and edge events
	// In split mode the second timer keeps counting for baud rates unless it is itself in split mode, but may not touch its flag.
	assign ov0      = tcs_overflow(first_timer_mode, first_timer_tick);                       // [RULE3] [RULE7]
	assign ov0_hi   = (first_timer_mode == tcs_pkg::TCS_MODE_SPLIT) && first_timer_upper_byte_inc
	                  && (first_timer_tick.count[15:8] == tcs_pkg::TCS_MAX8);                 // [RULE8]
	assign ov1      = (first_timer_mode != tcs_pkg::TCS_MODE_SPLIT)
	                  && tcs_overflow(second_timer_mode, second_timer_tick);                  // [RULE1] [RULE7]
	assign set_ovf1   = ov0_hi || ov1;
	assign pend0_edge = ext_irq0_input && !s_q.irq0_prev;
	assign pend1_edge = ext_irq1_input && !s_q.irq1_prev;

	// ==========================================================
	// Next-state logic
	// Each overflow flag, and each pending flag in edge mode, is written as (write-or-hold, then vector clear) OR set, so a set never gets lost.
	always_comb begin
		s_d = s_q;
		s_d.irq0_prev = ext_irq0_input;
		s_d.irq1_prev = ext_irq1_input;
		// Plain control bits.
		if (sw_hit[tcs_pkg::TCS_BIT_RUN0]) begin
			s_d.ctrl[tcs_pkg::TCS_BIT_RUN0] = sw_val[tcs_pkg::TCS_BIT_RUN0]; // [RULE5]
		end
		if (sw_hit[tcs_pkg::TCS_BIT_RUN1]) begin
			s_d.ctrl[tcs_pkg::TCS_BIT_RUN1] = sw_val[tcs_pkg::TCS_BIT_RUN1]; // [RULE5]
		end
		if (sw_hit[tcs_pkg::TCS_BIT_TYPE0]) begin
			s_d.ctrl[tcs_pkg::TCS_BIT_TYPE0] = sw_val[tcs_pkg::TCS_BIT_TYPE0];
		end
		if (sw_hit[tcs_pkg::TCS_BIT_TYPE1]) begin
			s_d.ctrl[tcs_pkg::TCS_BIT_TYPE1] = sw_val[tcs_pkg::TCS_BIT_TYPE1];
		end
		// Overflow flags.
		s_d.ctrl[tcs_pkg::TCS_BIT_OVF0] = ((sw_hit[tcs_pkg::TCS_BIT_OVF0] ? sw_val[tcs_pkg::TCS_BIT_OVF0]
		                                    : s_q.ctrl[tcs_pkg::TCS_BIT_OVF0]) && !vec_ack.ovf0) || ov0; // [RULE4] [RULE10]
		s_d.ctrl[tcs_pkg::TCS_BIT_OVF1] = ((sw_hit[tcs_pkg::TCS_BIT_OVF1] ? sw_val[tcs_pkg::TCS_BIT_OVF1]
		                                    : s_q.ctrl[tcs_pkg::TCS_BIT_OVF1]) && !vec_ack.ovf1) || set_ovf1; // [RULE2] [RULE10]
		// External flags follow the input in level mode and latch edges in edge mode.
		// The new type is used, so a write that selects edge mode also keeps the pending bit it writes.
		if (s_d.ctrl[tcs_pkg::TCS_BIT_TYPE0]) begin
			s_d.ctrl[tcs_pkg::TCS_BIT_PEND0] = ((sw_hit[tcs_pkg::TCS_BIT_PEND0] ? sw_val[tcs_pkg::TCS_BIT_PEND0]
			                                    : s_q.ctrl[tcs_pkg::TCS_BIT_PEND0]) && !vec_ack.pend0) || pend0_edge;
		end else begin
			s_d.ctrl[tcs_pkg::TCS_BIT_PEND0] = ext_irq0_input;
		end
		if (s_d.ctrl[tcs_pkg::TCS_BIT_TYPE1]) begin
			s_d.ctrl[tcs_pkg::TCS_BIT_PEND1] = ((sw_hit[tcs_pkg::TCS_BIT_PEND1] ? sw_val[tcs_pkg::TCS_BIT_PEND1]
			                                    : s_q.ctrl[tcs_pkg::TCS_BIT_PEND1]) && !vec_ack.pend1) || pend1_edge; // [RULE9]
		end else begin
			s_d.ctrl[tcs_pkg::TCS_BIT_PEND1] = ext_irq1_input; // [RULE9]
		end
		// Count enables are registered, so a run change reaches the counters one cycle later.
		s_d.run0_lo = s_q.ctrl[tcs_pkg::TCS_BIT_RUN0]
		              && (!first_timer_gate_bit || ext_irq0_input); // [RULE5] [RULE6]
		s_d.run0_hi = (first_timer_mode == tcs_pkg::TCS_MODE_SPLIT)
		              && s_q.ctrl[tcs_pkg::TCS_BIT_RUN1]; // [RULE8]
		if (first_timer_mode == tcs_pkg::TCS_MODE_SPLIT) begin
			s_d.run1 = (second_timer_mode != tcs_pkg::TCS_MODE_SPLIT);
		end else begin
			s_d.run1 = s_q.ctrl[tcs_pkg::TCS_BIT_RUN1] && (second_timer_mode != tcs_pkg::TCS_MODE_SPLIT)
			           && (!second_timer_gate_bit || ext_irq1_input); // [RULE5]
		end
		// Read data: the register on a hit, zero for any other address.
		if (sfr_req.rd && ctrl_sel) begin
			s_d.rdata = s_q.ctrl;
		end else if (sfr_req.rd) begin
			s_d.rdata = '0;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= tcs_pkg::TCS_STATE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign timer_run_and_flag_control = s_q.ctrl;
	assign sfr_rdata                  = s_q.rdata;
	assign first_timer_count_en       = s_q.run0_lo;
	assign first_timer_upper_count_en = s_q.run0_hi;
	assign second_timer_count_en      = s_q.run1;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_sw_clear_ovf0;
		sw_hit[tcs_pkg::TCS_BIT_OVF0] && !sw_val[tcs_pkg::TCS_BIT_OVF0];
	endsequence
	sequence s_roll13;
		(first_timer_mode == tcs_pkg::TCS_MODE_13BIT) && first_timer_tick.inc
		&& (first_timer_tick.count[12:0] == tcs_pkg::TCS_MAX13);
	endsequence

	property p_ovf1_set;
		set_ovf1 |=> timer_run_and_flag_control[tcs_pkg::TCS_BIT_OVF1];
	endproperty
	a_ovf1_set: assert property (p_ovf1_set) else $error("second overflow flag not set"); // [RULE1]

	property p_ovf1_ack;
		vec_ack.ovf1 && !set_ovf1 |=> !timer_run_and_flag_control[tcs_pkg::TCS_BIT_OVF1];
	endproperty
	a_ovf1_ack: assert property (p_ovf1_ack) else $error("second overflow flag kept after vector"); // [RULE2]

	property p_ovf0_set;
		ov0 |=> timer_run_and_flag_control[tcs_pkg::TCS_BIT_OVF0];
	endproperty
	a_ovf0_set: assert property (p_ovf0_set) else $error("first overflow flag not set"); // [RULE3]

	property p_ovf0_ack;
		vec_ack.ovf0 && !ov0 |=> !timer_run_and_flag_control[tcs_pkg::TCS_BIT_OVF0];
	endproperty
	a_ovf0_ack: assert property (p_ovf0_ack) else $error("first overflow flag kept after vector"); // [RULE4]

	property p_run0_write;
		sw_hit[tcs_pkg::TCS_BIT_RUN0] |=> timer_run_and_flag_control[tcs_pkg::TCS_BIT_RUN0]
		                                  == $past(sw_val[tcs_pkg::TCS_BIT_RUN0]);
	endproperty
	a_run0_write: assert property (p_run0_write) else $error("first run bit did not take write"); // [RULE5]

	property p_first_timer_gate_bit;
		timer_run_and_flag_control[tcs_pkg::TCS_BIT_RUN0] && first_timer_gate_bit && !ext_irq0_input
		|=> !first_timer_count_en ##1 (first_timer_count_en
		    == $past(timer_run_and_flag_control[tcs_pkg::TCS_BIT_RUN0] && (!first_timer_gate_bit || ext_irq0_input)));
	endproperty
	a_first_timer_gate_bit: assert property (p_first_timer_gate_bit) else $error("first timer ran while gated off"); // [RULE6]

	property p_roll13;
		s_roll13 |=> timer_run_and_flag_control[tcs_pkg::TCS_BIT_OVF0];
	endproperty
	a_roll13: assert property (p_roll13) else $error("13-bit roll-over missed"); // [RULE7]

	property p_split_hi;
		(first_timer_mode == tcs_pkg::TCS_MODE_SPLIT) |=> first_timer_upper_count_en
		                                                   == $past(timer_run_and_flag_control[tcs_pkg::TCS_BIT_RUN1]);
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("upper byte enable wrong"); // [RULE8]

	property p_pend1_level;
		!timer_run_and_flag_control[tcs_pkg::TCS_BIT_TYPE1] && !sw_hit[tcs_pkg::TCS_BIT_TYPE1]
		|=> timer_run_and_flag_control[tcs_pkg::TCS_BIT_PEND1] == $past(ext_irq1_input);
	endproperty
	a_pend1_level: assert property (p_pend1_level) else $error("level flag does not follow input"); // [RULE9]

	property p_set_wins;
		(s_sw_clear_ovf0 and ov0) |=> timer_run_and_flag_control[tcs_pkg::TCS_BIT_OVF0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("overflow lost to clear"); // [RULE10]

endmodule : tcs_timer_control

// *** verification/tb_timer01_control_status.sv ***
// Self-checking testbench for the timer run and flag control register.
`timescale 1ns/100ps
module tb_timer01_control_status;
	logic                  clk = 1'b0;
	logic                  reset = 1'b1;
	tcs_pkg::tcs_sfr_req_t req = '0;
	tcs_pkg::tcs_vec_ack_t ack = '0;
	tcs_pkg::tcs_tick_t    tk0 = '0;
	tcs_pkg::tcs_tick_t    tk1 = '0;
	logic [1:0]            m0 = 2'h1;
	logic [1:0]            m1 = 2'h1;
	logic                  g0 = 1'b0;
	logic                  g1 = 1'b0;
	logic                  up_inc = 1'b0;
	logic                  irq0 = 1'b0;
	logic                  irq1 = 1'b0;
	logic [7:0]            rdata;
	logic [7:0]            ctrl_reg;
	logic                  en0;
	logic                  en0_hi;
	logic                  en1;
	int                    miscompares = 0;
	int                    num_checks = 0;
	logic [7:0]            d;

	// ==========================================================
	// Clock and device under test
	always #20 clk = ~clk;
	tcs_timer_control u_dut (.clk(clk), .reset(reset), .sfr_req(req), .sfr_rdata(rdata), .vec_ack(ack),
		.first_timer_mode(m0), .second_timer_mode(m1), .first_timer_gate_bit(g0),
		.second_timer_gate_bit(g1), .first_timer_tick(tk0), .first_timer_upper_byte_inc(up_inc),
		.second_timer_tick(tk1), .ext_irq0_input(irq0), .ext_irq1_input(irq1),
		.timer_run_and_flag_control(ctrl_reg), .first_timer_count_en(en0),
		.first_timer_upper_count_en(en0_hi), .second_timer_count_en(en1));

	// ==========================================================
	// Checking and closing tasks
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// One register bus request; the request is taken at the second edge.
	task automatic sfr(input logic w, input logic b, input logic r, input logic [7:0] a,
			input logic [2:0] s, input logic [7:0] v);
		@(posedge clk);
		req.wr <= w;
		req.bit_wr <= b;
		req.rd <= r;
		req.addr <= a;
		req.bit_sel <= s;
		req.wdata <= v;
		@(posedge clk);
		req.wr <= 1'b0;
		req.bit_wr <= 1'b0;
		req.rd <= 1'b0;
		#1;
	endtask : sfr

	// One overflow candidate tick on either timer, or on the split upper byte.
	task automatic tick(input bit sec, input logic [15:0] cnt, input bit hi);
		@(posedge clk);
		if (hi) up_inc <= 1'b1;
		else if (sec) tk1 <= '{inc: 1'b1, count: cnt};
		else tk0 <= '{inc: 1'b1, count: cnt};
		@(posedge clk);
		tk0.inc <= 1'b0;
		tk1.inc <= 1'b0;
		up_inc <= 1'b0;
		#1;
	endtask : tick

	task automatic vec(input tcs_pkg::tcs_vec_ack_t v);
		@(posedge clk);
		ack <= v;
		@(posedge clk);
		ack <= '0;
		#1;
	endtask : vec

	// Level-mode pending bits cannot be held by software, so they read back as the idle inputs.
	function automatic logic [7:0] exp_reg(input logic [7:0] v);
		exp_reg = v;
		if (!v[2]) exp_reg[3] = 1'b0;
		if (!v[0]) exp_reg[1] = 1'b0;
	endfunction : exp_reg

	// Watchdog so that a hung run still reaches the verdict.
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'hf35c3f55));
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk("reset", ctrl_reg, tcs_pkg::TCS_CTRL_RESET);
		// Run bits start both timers and stop the first, enables lag by one cycle.
		sfr(1, 0, 0, tcs_pkg::TCS_CTRL_ADDR, 3'h0, 8'h50);
		@(posedge clk);
		#1;
		chk("run", {ctrl_reg, en0, en1}, {8'h50, 2'b11});
		// Gate high with inactive input holds the first timer off.
		g0 <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("gate_off", en0, 1'b0);
		irq0 <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("gate_on", en0, 1'b1);
		irq0 <= 1'b0;
		g0 <= 1'b0;
		sfr(0, 1, 0, tcs_pkg::TCS_CTRL_ADDR, 3'h4, 8'h00);
		@(posedge clk);
		#1;
		chk("stop", {ctrl_reg[4], en0}, 2'b00);
		// Second timer: a non-final count leaves the flag, the roll-over sets it, the vector clears it.
		tick(1, 16'hFFFE, 0);
		chk("ovf1_early", ctrl_reg[7], 1'b0);
		tick(1, tcs_pkg::TCS_MAX16, 0);
		chk("ovf1_set", ctrl_reg[7], 1'b1);
		vec('{ovf0: 1'b0, ovf1: 1'b1, pend0: 1'b0, pend1: 1'b0});
		chk("ovf1_vec", ctrl_reg[7], 1'b0);
		tick(1, tcs_pkg::TCS_MAX16, 0);
		sfr(0, 1, 0, tcs_pkg::TCS_CTRL_ADDR, 3'h7, 8'h00);
		chk("ovf1_sw", ctrl_reg[7], 1'b0);
		// First timer in the thirteen-bit mode rolls over at the thirteen-bit maximum.
		m0 <= tcs_pkg::TCS_MODE_13BIT;
		tick(0, 16'h1FFE, 0);
		chk("ovf0_early", ctrl_reg[5], 1'b0);
		tick(0, {3'h0, tcs_pkg::TCS_MAX13}, 0);
		chk("ovf0_set", ctrl_reg[5], 1'b1);
		vec('{ovf0: 1'b1, ovf1: 1'b0, pend0: 1'b0, pend1: 1'b0});
		chk("ovf0_vec", ctrl_reg[5], 1'b0);
		tick(0, {3'h0, tcs_pkg::TCS_MAX13}, 0);
		sfr(1, 0, 0, tcs_pkg::TCS_CTRL_ADDR, 3'h0, 8'h00);
		chk("ovf0_sw", ctrl_reg[5], 1'b0);
		// Overflow and software clear in the same cycle keep the flag.
		@(posedge clk);
		tk0 <= '{inc: 1'b1, count: {3'h0, tcs_pkg::TCS_MAX13}};
		req <= '{wr: 1'b0, bit_wr: 1'b1, rd: 1'b0, addr: tcs_pkg::TCS_CTRL_ADDR, bit_sel: 3'h5, wdata: 8'h00};
		@(posedge clk);
		tk0.inc <= 1'b0;
		req.bit_wr <= 1'b0;
		#1;
		chk("race", ctrl_reg[5], 1'b1);
		// Split mode: upper byte follows the second run bit and sets the second flag.
		m0 <= tcs_pkg::TCS_MODE_SPLIT;
		sfr(1, 0, 0, tcs_pkg::TCS_CTRL_ADDR, 3'h0, 8'h40);
		@(posedge clk);
		#1;
		chk("split_en", en0_hi, 1'b1);
		chk("split_pre", ctrl_reg[7], 1'b0);
		tk0.count <= 16'hFF00;
		tick(0, 16'hFF00, 1);
		chk("split_ovf1", ctrl_reg[7], 1'b1);
		m0 <= tcs_pkg::TCS_MODE_16BIT;
		// Edge mode latches a pulse; level mode follows the input.
		sfr(1, 0, 0, tcs_pkg::TCS_CTRL_ADDR, 3'h0, 8'h04);
		irq1 <= 1'b1;
		repeat (2) @(posedge clk);
		irq1 <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("edge_pend1", ctrl_reg[3], 1'b1);
		vec('{ovf0: 1'b0, ovf1: 1'b0, pend0: 1'b0, pend1: 1'b1});
		chk("edge_clr", ctrl_reg[3], 1'b0);
		sfr(1, 0, 0, tcs_pkg::TCS_CTRL_ADDR, 3'h0, 8'h00);
		irq1 <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("lvl_hi", ctrl_reg[3], 1'b1);
		irq1 <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("lvl_lo", ctrl_reg[3], 1'b0);
		// Random byte writes with read back, and ignored accesses elsewhere.
		for (int i = 0; i < 24; i++) begin
			d = 8'($urandom);
			sfr(1, 0, 0, tcs_pkg::TCS_CTRL_ADDR, 3'h0, d);
			sfr(1, 0, 0, {4'h9, 4'($urandom)}, 3'h0, ~d);
			sfr(0, 0, 1, tcs_pkg::TCS_CTRL_ADDR, 3'h0, 8'h00);
			chk("rd", rdata, exp_reg(d));
			sfr(0, 0, 1, {4'h9, 4'($urandom)}, 3'h0, 8'h00);
			chk("rd_unmapped", rdata, 8'h00);
		end
		report_and_stop();
	end
endmodule : tb_timer01_control_status
